// ---- pkg/tec_guard_map.svh ----
// Constants for the cooler limit and fault guard
`ifndef TEC_GUARD_MAP_SVH
`define TEC_GUARD_MAP_SVH
`define PWM_HALF_DUTY     13'h0800
`define PWM_MIN_DUTY      13'h0334
`define PWM_MAX_DUTY      13'h0ccc
`define VCTL_OFFSET_MV    32'sh0000_05dc
`define VCTL_CEIL_MV      32'sh0000_0bb8
`define VCTL_FLOOR_MV     32'sh0000_0000
`define VCTL_GAIN_SHIFT   8
`define DAC_INT_REF_MV    16'h09c4
`define DAC_FULL_CODE     28'h000_0fff
`define DAC_BIAS_CH       3'h4
`define STREAK_FAULT_LEN  2'h3
`endif

// ---- pkg/tec_guard_pkg.sv ----
// Types for the cooler limit and fault guard
package tec_guard_pkg;
  typedef enum logic [1:0] {
    CTL_OFF   = 2'b00,
    CTL_RUN   = 2'b01,
    CTL_FORCE = 2'b10,
    CTL_HALT  = 2'b11
  } ctl_state_t;
  typedef enum logic [1:0] {
    VIOL_NONE  = 2'b00,
    VIOL_OVER  = 2'b01,
    VIOL_UNDER = 2'b10
  } viol_t;
endpackage

// ---- logic/violation_counter.sv ----
// Consecutive same-kind violation counter for one fault type
`timescale 1ns/100ps
`include "tec_guard_map.svh"
module violation_counter
  import tec_guard_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clear,     // Drop the streak and the fault
  input  wire logic strobe,    // One comparison done this cycle
  input  wire logic over,      // Above the positive limit
  input  wire logic under,     // Below the negative limit
  output logic      fault      // Fault declared, held until clear
);
  viol_t      kind_reg;        // Kind of the running streak
  logic [1:0] count_reg;       // Length of the running streak
  viol_t      kind_now;        // Kind seen at this comparison

  assign kind_now = over ? VIOL_OVER : (under ? VIOL_UNDER : VIOL_NONE);

  // Streak tracking
  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      kind_reg  <= VIOL_NONE;
      count_reg <= 2'h0;
    end else if (strobe) begin
      if (kind_now == VIOL_NONE) begin
        count_reg <= 2'h0;
        kind_reg  <= VIOL_NONE;
      end else if (kind_now == kind_reg && count_reg != `STREAK_FAULT_LEN) begin
        count_reg <= count_reg + 2'h1;
      end else if (kind_now != kind_reg) begin
        count_reg <= 2'h1; // Different event restarts the streak
        kind_reg  <= kind_now;
      end
    end
  end

  // Fault flag: a new hit wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault <= 1'b0;
    end else if (strobe && kind_now != VIOL_NONE && kind_now == kind_reg &&
                 count_reg == `STREAK_FAULT_LEN - 2'h1) begin
      fault <= 1'b1;
    end else if (clear) begin
      fault <= 1'b0;
    end
  end

  chk_streak_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (strobe && !over && !under && !clear) |=> count_reg == 2'h0)
    else $error("streak not reset by a clean comparison");
endmodule // violation_counter

// ---- logic/tec_limit_and_fault_guard.sv ----
// Limit clamps, fault detection, duty update and bias DAC for the cooler loop
`timescale 1ns/100ps
`include "tec_guard_map.svh"
module tec_limit_and_fault_guard
  import tec_guard_pkg::*;
#(
  parameter int DAC_CHANNELS = 8
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     control_enable,          // Software wants the loop running
  input  wire logic signed [15:0]       pos_current_fault_limit, // mA
  input  wire logic signed [15:0]       neg_current_fault_limit, // mA
  input  wire logic signed [15:0]       pos_current_target_limit,// mA
  input  wire logic signed [15:0]       neg_current_target_limit,// mA
  input  wire logic signed [15:0]       pos_voltage_fault_limit, // mV
  input  wire logic signed [15:0]       neg_voltage_fault_limit, // mV
  input  wire logic signed [15:0]       sense_gain,              // 10 x Rsense, Q8, mV per mA
  input  wire logic                     meas_valid,              // Fresh ADC pair this cycle
  input  wire logic signed [15:0]       meas_current,            // mA
  input  wire logic signed [15:0]       meas_voltage,            // mV
  input  wire logic signed [15:0]       current_target_in,       // mA
  input  wire logic signed [15:0]       control_voltage_in,      // mV
  input  wire logic signed [15:0]       integrator_error_in,     // mA
  input  wire logic                     duty_write,              // Load pending duties
  input  wire logic [12:0]              duty_a_in,               // Clock cycles of 4096
  input  wire logic [12:0]              duty_b_in,
  input  wire logic                     update_req,              // Global duty update request
  input  wire logic                     dac_cfg_write,
  input  wire logic                     dac_data_write,
  input  wire logic [2:0]               dac_channel,
  input  wire logic                     dac_enable_in,
  input  wire logic                     dac_ref_sel_in,          // 1 internal, 0 alternate
  input  wire logic [11:0]              dac_code_in,
  input  wire logic [15:0]              alt_ref_mv,              // Alternate reference level
  output logic signed [15:0]            current_target_out,
  output logic signed [15:0]            control_voltage_out,
  output logic signed [15:0]            integrator_error_out,
  output logic [12:0]                   bridge_a_high_drive_duty,
  output logic [12:0]                   bridge_b_high_drive_duty,
  output logic                          pwm_update,
  output logic                          bridge_a_high_drive,
  output logic                          bridge_b_high_drive,
  output logic                          control_active,
  output logic                          current_fault,
  output logic                          voltage_fault,
  output logic [DAC_CHANNELS-1:0]       dac_enable,
  output logic                          bias_dac_ref_internal,
  output logic [11:0]                   bias_dac_code,
  output logic [15:0]                   bias_dac_out_mv
);
  ctl_state_t         state_reg;        // Loop control state
  logic signed [15:0] pcf_reg, ncf_reg; // Held current fault limits
  logic signed [15:0] ptl_reg, ntl_reg; // Held target limits
  logic signed [15:0] pvf_reg, nvf_reg; // Held voltage fault limits
  logic signed [15:0] gain_reg;         // Held sense gain
  logic signed [15:0] cur_smp_reg;      // Captured current sample
  logic signed [15:0] volt_smp_reg;     // Captured voltage sample
  logic               cmp_go_reg;       // Compare stage strobe
  logic [12:0]        pend_a_reg, pend_b_reg; // Written, not yet live
  logic [11:0]        pwm_cnt_reg;      // Period counter
  logic [DAC_CHANNELS-1:0] dac_ref_reg; // Reference selects
  logic [11:0]        dac_code_reg [DAC_CHANNELS]; // Data registers
  logic signed [31:0] vhi_raw, vlo_raw, span;
  logic [15:0]        bias_ref_mv;
  logic [27:0]        bias_prod;
  logic               cur_hit, volt_hit;

  // Saturating clamp into 16 bits
  function automatic logic signed [15:0] clamp16(input logic signed [31:0] v,
                                                  input logic signed [31:0] lo,
                                                  input logic signed [31:0] hi);
    logic signed [31:0] r;
    r = v;
    if (r > hi) r = hi;
    if (r < lo) r = lo;
    return r[15:0];
  endfunction

  // Duty band limit
  function automatic logic [12:0] band(input logic [12:0] d);
    logic [12:0] r;
    r = d;
    if (r < `PWM_MIN_DUTY) r = `PWM_MIN_DUTY;
    if (r > `PWM_MAX_DUTY) r = `PWM_MAX_DUTY;
    return r;
  endfunction

  // Limit configuration capture only while the loop is off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {pcf_reg, ncf_reg, ptl_reg, ntl_reg} <= '0;
      {pvf_reg, nvf_reg, gain_reg}        <= '0;
    end else if (state_reg == CTL_OFF) begin
      pcf_reg  <= pos_current_fault_limit;
      ncf_reg  <= neg_current_fault_limit;
      ptl_reg  <= pos_current_target_limit;
      ntl_reg  <= neg_current_target_limit;
      pvf_reg  <= pos_voltage_fault_limit;
      nvf_reg  <= neg_voltage_fault_limit;
      gain_reg <= sense_gain;
    end
  end

  // Derived clamp bounds
  assign vhi_raw = ((32'(ptl_reg) * 32'(gain_reg)) >>> `VCTL_GAIN_SHIFT) + `VCTL_OFFSET_MV;
  assign vlo_raw = ((32'(ntl_reg) * 32'(gain_reg)) >>> `VCTL_GAIN_SHIFT) + `VCTL_OFFSET_MV;
  assign span    = 32'(ptl_reg) - 32'(ntl_reg);

  // Clamped loop quantities
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      current_target_out   <= '0;
      control_voltage_out  <= '0;
      integrator_error_out <= '0;
    end else begin
      current_target_out   <= clamp16(32'(current_target_in), 32'(ntl_reg), 32'(ptl_reg));
      control_voltage_out  <= clamp16(32'(control_voltage_in),
                                      (vlo_raw > `VCTL_FLOOR_MV) ? vlo_raw : `VCTL_FLOOR_MV,
                                      (vhi_raw < `VCTL_CEIL_MV) ? vhi_raw : `VCTL_CEIL_MV);
      integrator_error_out <= clamp16(32'(integrator_error_in), -span, span);
    end
  end

  // Sample capture, compare one cycle later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_smp_reg  <= '0;
      volt_smp_reg <= '0;
      cmp_go_reg   <= 1'b0;
    end else begin
      if (meas_valid) begin
        cur_smp_reg  <= meas_current;
        volt_smp_reg <= meas_voltage;
      end
      cmp_go_reg <= meas_valid && state_reg == CTL_RUN;
    end
  end

  // Per-type streak counters
  violation_counter u_cur_streak (
    .clk    (clk),
    .sys_rst(sys_rst),
    .clear  (state_reg == CTL_OFF),
    .strobe (cmp_go_reg),
    .over   (cur_smp_reg > pcf_reg),
    .under  (cur_smp_reg < ncf_reg),
    .fault  (current_fault)
  );
  violation_counter u_volt_streak (
    .clk    (clk),
    .sys_rst(sys_rst),
    .clear  (state_reg == CTL_OFF),
    .strobe (cmp_go_reg),
    .over   (volt_smp_reg > pvf_reg),
    .under  (volt_smp_reg < nvf_reg),
    .fault  (voltage_fault)
  );
  assign cur_hit  = current_fault;
  assign volt_hit = voltage_fault;

  // Loop control state machine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= CTL_OFF;
    end else begin
      case (state_reg)
        CTL_OFF:   if (control_enable) state_reg <= CTL_RUN;
        CTL_RUN: begin
          if (cur_hit || volt_hit) state_reg <= CTL_FORCE;
          else if (!control_enable) state_reg <= CTL_OFF;
        end
        CTL_FORCE: state_reg <= CTL_HALT;
        CTL_HALT:  if (!control_enable) state_reg <= CTL_OFF;
        default:   state_reg <= CTL_OFF;
      endcase
    end
  end

  // Control active flag
  always_ff @(posedge clk) begin
    if (sys_rst) control_active <= 1'b0;
    else control_active <= (state_reg == CTL_RUN && !cur_hit && !volt_hit) ||
                           (state_reg == CTL_OFF && control_enable);
  end

  // Pending duties and the self-clearing update strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_a_reg <= `PWM_HALF_DUTY;
      pend_b_reg <= `PWM_HALF_DUTY;
      pwm_update <= 1'b0;
    end else if (state_reg == CTL_FORCE) begin
      pend_a_reg <= `PWM_HALF_DUTY;
      pend_b_reg <= `PWM_HALF_DUTY;
      pwm_update <= 1'b1;
    end else begin
      if (duty_write && state_reg == CTL_RUN) begin
        pend_a_reg <= band(duty_a_in);
        pend_b_reg <= band(duty_b_in);
      end
      pwm_update <= update_req && state_reg == CTL_RUN;
    end
  end

  // Live duties load only on the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bridge_a_high_drive_duty <= `PWM_HALF_DUTY;
      bridge_b_high_drive_duty <= `PWM_HALF_DUTY;
    end else if (pwm_update) begin
      bridge_a_high_drive_duty <= pend_a_reg;
      bridge_b_high_drive_duty <= pend_b_reg;
    end
  end

  // 4096-cycle period and drive pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwm_cnt_reg         <= '0;
      bridge_a_high_drive <= 1'b0;
      bridge_b_high_drive <= 1'b0;
    end else begin
      pwm_cnt_reg         <= pwm_cnt_reg + 12'h001;
      bridge_a_high_drive <= {1'b0, pwm_cnt_reg} < bridge_a_high_drive_duty;
      bridge_b_high_drive <= {1'b0, pwm_cnt_reg} < bridge_b_high_drive_duty;
    end
  end

  // DAC channel configuration and data registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dac_enable  <= '0;
      dac_ref_reg <= '0;
      for (int i = 0; i < DAC_CHANNELS; i++) dac_code_reg[i] <= '0;
    end else begin
      if (dac_cfg_write) begin
        dac_enable[dac_channel]  <= dac_enable_in;
        dac_ref_reg[dac_channel] <= dac_ref_sel_in;
      end
      if (dac_data_write) dac_code_reg[dac_channel] <= dac_code_in;
    end
  end

  // Bias channel output level
  assign bias_ref_mv = dac_ref_reg[`DAC_BIAS_CH] ? `DAC_INT_REF_MV : alt_ref_mv;
  assign bias_prod   = 28'(dac_code_reg[`DAC_BIAS_CH]) * 28'(bias_ref_mv);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bias_dac_ref_internal <= 1'b0;
      bias_dac_code         <= '0;
      bias_dac_out_mv       <= '0;
    end else begin
      bias_dac_ref_internal <= dac_ref_reg[`DAC_BIAS_CH];
      bias_dac_code         <= dac_code_reg[`DAC_BIAS_CH];
      bias_dac_out_mv       <= dac_enable[`DAC_BIAS_CH] ?
                               16'(bias_prod / `DAC_FULL_CODE) : 16'h0000;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_duty_band: assert property (pwm_update && state_reg == CTL_RUN |=>
    bridge_a_high_drive_duty >= `PWM_MIN_DUTY && bridge_a_high_drive_duty <= `PWM_MAX_DUTY)
    else $error("duty outside band");
  chk_update_pulse: assert property (pwm_update && state_reg != CTL_FORCE |=> !pwm_update || $past(update_req))
    else $error("update strobe held without request");
  chk_duty_hold: assert property (!pwm_update |=> $stable(bridge_a_high_drive_duty))
    else $error("duty changed without strobe");
  chk_fault_force: assert property ((cur_hit || volt_hit) && state_reg == CTL_RUN |=>
    state_reg == CTL_FORCE ##1 (pwm_update && !control_active) ##1
    (bridge_a_high_drive_duty == `PWM_HALF_DUTY && bridge_b_high_drive_duty == `PWM_HALF_DUTY))
    else $error("fault did not force neutral duty");
  chk_target_clamp: assert property (##1 current_target_out <= $past(ptl_reg) &&
    current_target_out >= $past(ntl_reg) || $past(ntl_reg) > $past(ptl_reg))
    else $error("current target out of limits");
  chk_err_clamp: assert property (span >= 0 && $stable(span) |=>
    32'(integrator_error_out) <= $past(span) && 32'(integrator_error_out) >= -$past(span))
    else $error("integrator error out of span");
  chk_vctl_ceil: assert property (##1 32'(control_voltage_out) <= `VCTL_CEIL_MV)
    else $error("control voltage above ceiling");
  chk_cfg_frozen: assert property (state_reg != CTL_OFF |=> $stable(pcf_reg) && $stable(pvf_reg))
    else $error("limits changed while running");
  chk_fresh_first: assert property (cmp_go_reg |-> $past(meas_valid))
    else $error("compare without fresh sample");
  chk_dac_enable: assert property (dac_cfg_write |=> dac_enable[$past(dac_channel)] == $past(dac_enable_in))
    else $error("dac enable not applied");
  chk_dac_full: assert property (dac_enable[`DAC_BIAS_CH] && dac_code_reg[`DAC_BIAS_CH] == 12'hfff &&
    $stable(bias_ref_mv) |=> bias_dac_out_mv == $past(bias_ref_mv))
    else $error("full code is not full scale");
  chk_pwm_wrap: assert property (pwm_cnt_reg == 12'hfff |=> pwm_cnt_reg == 12'h000)
    else $error("pwm period wrong");

  cov_fault_cur: cover property (state_reg == CTL_RUN && cur_hit);
  cov_fault_volt: cover property (state_reg == CTL_RUN && volt_hit);
  cov_update: cover property (duty_write ##1 update_req ##1 pwm_update);
  cov_bias_on: cover property (dac_enable[`DAC_BIAS_CH] && bias_dac_out_mv != 16'h0000);
endmodule // tec_limit_and_fault_guard

// ---- verif/tec_far_side_model.sv ----
// Far-side model: ADC sample source and bridge pin timing monitor
`timescale 1ns/100ps
module tec_far_side_model (
  input  wire logic               clk,
  input  wire logic               sample_req,          // Bench asks for one ADC pair
  input  wire logic signed [15:0] sample_current,      // mA to deliver
  input  wire logic signed [15:0] sample_voltage,      // mV to deliver
  input  wire logic               bridge_a_high_drive, // Bridge pin under watch
  output logic                    meas_valid,
  output logic signed [15:0]      meas_current,
  output logic signed [15:0]      meas_voltage,
  output logic [15:0]             a_high_cycles,       // Last high time in cycles
  output logic [15:0]             a_period             // Last rise to rise in cycles
);
  logic [15:0] high_cnt;  // Cycles high so far
  logic [15:0] per_cnt;   // Cycles since last rise
  logic        pin_reg;   // Pin one cycle ago
  // Known start so the toggling pattern is defined
  initial begin
    {meas_valid, meas_current, meas_voltage, a_high_cycles, a_period} = '0;
    {high_cnt, per_cnt, pin_reg} = '0;
  end
  // Sample delivery; stale data toggles so it never looks fresh
  always @(posedge clk) begin
    meas_valid <= sample_req;
    meas_current <= sample_req ? sample_current : ~meas_current;
    meas_voltage <= sample_req ? sample_voltage : ~meas_voltage;
  end
  // High time and period of the bridge pin
  always @(posedge clk) begin
    pin_reg <= bridge_a_high_drive;
    high_cnt <= bridge_a_high_drive ? high_cnt + 16'h0001 : 16'h0000;
    per_cnt <= (bridge_a_high_drive && !pin_reg) ? 16'h0001 : per_cnt + 16'h0001;
    if (!bridge_a_high_drive && pin_reg) a_high_cycles <= high_cnt;
    if (bridge_a_high_drive && !pin_reg) a_period <= per_cnt;
  end
endmodule // tec_far_side_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the cooler limit and fault guard
`timescale 1ns/100ps
`include "tec_guard_map.svh"
module tb_top
  import tec_guard_pkg::*;
;
  typedef struct {int k; logic [15:0] v; int due;} note_t;
  logic clk = 1'b0, sys_rst = 1'b1, control_enable, meas_valid, duty_write, update_req, sample_req;
  logic dac_cfg_write, dac_data_write, dac_enable_in, dac_ref_sel_in;
  logic signed [15:0] pos_current_fault_limit, neg_current_fault_limit, pos_voltage_fault_limit;
  logic signed [15:0] neg_voltage_fault_limit, pos_current_target_limit, neg_current_target_limit, sense_gain;
  logic signed [15:0] meas_current, meas_voltage, current_target_in, control_voltage_in, integrator_error_in;
  logic signed [15:0] sample_current, sample_voltage, current_target_out, control_voltage_out, integrator_error_out;
  logic [12:0]        duty_a_in, duty_b_in, bridge_a_high_drive_duty, bridge_b_high_drive_duty;
  logic [2:0]         dac_channel;
  logic [11:0]        dac_code_in, bias_dac_code;
  logic [15:0]        alt_ref_mv, bias_dac_out_mv, a_high_cycles, a_period, got;
  logic [7:0]         dac_enable, mask;
  logic               pwm_update, bridge_a_high_drive, bridge_b_high_drive, control_active, current_fault, voltage_fault;
  logic               bias_dac_ref_internal, b_en;
  int                 failures = 0, samples_checked = 0, cyc = 0, ref_v, b_code, ptl, hi, lo, a, b, c;
  note_t              notes[$];  // Expected results, oldest first
  string nm [16] = '{"current_target", "control_voltage", "integrator_error", "duty_a", "duty_b", "pwm_update",
    "control_active", "current_fault", "voltage_fault", "dac_enable", "bias_ref_internal", "bias_code",
    "bias_out_mv", "a_high_cycles", "a_period", "bridge_b_pin"};
  int cur_seq [8] = '{701, 800, 700, 900, 750, -701, -800, -900};

  tec_limit_and_fault_guard #(.DAC_CHANNELS(8)) i_tec_limit_and_fault_guard (
    .clk, .sys_rst, .control_enable, .pos_current_fault_limit, .neg_current_fault_limit,
    .pos_current_target_limit, .neg_current_target_limit, .pos_voltage_fault_limit, .neg_voltage_fault_limit,
    .sense_gain, .meas_valid, .meas_current, .meas_voltage, .current_target_in, .control_voltage_in,
    .integrator_error_in, .duty_write, .duty_a_in, .duty_b_in, .update_req, .dac_cfg_write, .dac_data_write,
    .dac_channel, .dac_enable_in, .dac_ref_sel_in, .dac_code_in, .alt_ref_mv, .current_target_out,
    .control_voltage_out, .integrator_error_out, .bridge_a_high_drive_duty, .bridge_b_high_drive_duty,
    .pwm_update, .bridge_a_high_drive, .bridge_b_high_drive, .control_active, .current_fault, .voltage_fault,
    .dac_enable, .bias_dac_ref_internal, .bias_dac_code, .bias_dac_out_mv);
  tec_far_side_model i_tec_far_side_model (
    .clk, .sample_req, .sample_current, .sample_voltage, .bridge_a_high_drive, .meas_valid, .meas_current,
    .meas_voltage, .a_high_cycles, .a_period);

  // 100 MHz clock
  always #5 clk = ~clk;
  // Output value by note kind
  function automatic logic [15:0] seen(int k);
    case (k)
      0: return current_target_out;
      1: return control_voltage_out;
      2: return integrator_error_out;
      3: return {3'h0, bridge_a_high_drive_duty};
      4: return {3'h0, bridge_b_high_drive_duty};
      5: return {15'h0000, pwm_update};
      6: return {15'h0000, control_active};
      7: return {15'h0000, current_fault};
      8: return {15'h0000, voltage_fault};
      9: return {8'h00, dac_enable};
      10: return {15'h0000, bias_dac_ref_internal};
      11: return {4'h0, bias_dac_code};
      12: return bias_dac_out_mv;
      13: return a_high_cycles;
      14: return a_period;
      default: return {15'h0000, bridge_b_high_drive};
    endcase
  endfunction
  function automatic int clip(int x, int l, int h);
    return x > h ? h : (x < l ? l : x);
  endfunction
  function automatic int rnd();
    return int'($urandom_range(8000)) - 4000;
  endfunction
  function automatic int bias_mv();
    return b_en ? b_code * ref_v / int'(`DAC_FULL_CODE) : 0;
  endfunction
  // Record an expectation due lat edges after the current edge
  task automatic note(int k, logic [15:0] v, int lat);
    notes.push_back('{k, v, cyc + 1 + lat});
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  // One configuration pulse
  task automatic dac_cfg(int ch, logic en, logic rs);
    @(posedge clk);
    dac_cfg_write <= 1'b1;
    dac_channel <= 3'(ch);
    dac_enable_in <= en;
    dac_ref_sel_in <= rs;
    mask[ch] = en;
    if (ch == 4) begin
      b_en = en;
      ref_v = rs ? int'(`DAC_INT_REF_MV) : int'(alt_ref_mv);
    end
    note(9, {8'h00, mask}, 1);
    if (ch == 4) note(10, {15'h0000, rs}, 2);
    if (ch == 4) note(12, 16'(bias_mv()), 2);
    @(posedge clk);
    dac_cfg_write <= 1'b0;
  endtask
  // One data pulse
  task automatic dac_data(int ch, int code);
    @(posedge clk);
    dac_data_write <= 1'b1;
    dac_channel <= 3'(ch);
    dac_code_in <= 12'(code);
    if (ch == 4) b_code = code;
    note(11, 16'(b_code), 2);
    note(12, 16'(bias_mv()), 2);
    @(posedge clk);
    dac_data_write <= 1'b0;
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Compares each due note against the outputs
  always @(negedge clk) begin
    cyc = cyc + 1;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      got = seen(notes[0].k);
      samples_checked++;
      if (got !== notes[0].v) begin
        $display("MISMATCH %s expected %h seen %h", nm[notes[0].k], notes[0].v, got);
        failures++;
      end
      void'(notes.pop_front());
    end
  end
  // Hang guard
  initial begin
    tick(100000);
    failures++;
    stop_test();
  end
  // Main sequence
  initial begin
    {control_enable, duty_write, update_req, sample_req, dac_cfg_write, dac_data_write} = '0;
    {dac_enable_in, dac_ref_sel_in, dac_channel, dac_code_in, duty_a_in, duty_b_in, mask, b_en, b_code} = '0;
    {sample_current, sample_voltage, current_target_in, control_voltage_in, integrator_error_in} = '0;
    pos_current_fault_limit = 16'sh02bc;
    neg_current_fault_limit = -16'sh02bc;
    pos_voltage_fault_limit = 16'sh05dc;
    neg_voltage_fault_limit = -16'sh05dc;
    pos_current_target_limit = 16'sh012c;
    neg_current_target_limit = -16'sh012c;
    sense_gain = 16'sh0100;
    alt_ref_mv = 16'h0bb8;
    ref_v = 0;
    a = $urandom(32'h3fa7);
    tick(4);
    sys_rst <= 1'b0;
    note(3, 16'h0800, 0);
    note(6, 16'h0000, 0);
    note(9, 16'h0000, 0);
    // Clamps for two limit sets, one hitting the fixed ceiling and floor
    for (int s = 0; s < 2; s++) begin
      ptl = s ? 1000 : 300;
      @(posedge clk);
      pos_current_target_limit <= 16'(ptl);
      neg_current_target_limit <= 16'(-ptl);
      sense_gain <= s ? 16'sh0200 : 16'sh0100;
      tick(2);
      hi = clip(ptl * (s ? 512 : 256) / 256 + `VCTL_OFFSET_MV, -100000, `VCTL_CEIL_MV);
      lo = clip(-ptl * (s ? 512 : 256) / 256 + `VCTL_OFFSET_MV, `VCTL_FLOOR_MV, 100000);
      for (int i = 0; i < 20; i++) begin
        @(posedge clk);
        a = (i == 0) ? ptl + 1 : rnd();
        b = (i == 0) ? hi + 1 : (i == 1) ? lo - 1 : rnd();
        c = (i == 0) ? 2 * ptl + 1 : rnd();
        current_target_in <= 16'(a);
        control_voltage_in <= 16'(b);
        integrator_error_in <= 16'(c);
        note(0, 16'(clip(a, -ptl, ptl)), 1);
        note(1, 16'(clip(b, lo, hi)), 1);
        note(2, 16'(clip(c, -2 * ptl, 2 * ptl)), 1);
      end
    end
    // Bias DAC channels, codes and references
    for (int ch = 0; ch < 8; ch++) dac_cfg(ch, 1'($urandom_range(1)), 1'b1);
    dac_cfg(4, 1'b1, 1'b1);
    dac_data(4, 2457);
    dac_data(3, 100);
    dac_cfg(4, 1'b1, 1'b0);
    dac_data(4, 4095);
    dac_cfg(4, 1'b0, 1'b0);
    // Run; limits must hold while running
    @(posedge clk);
    control_enable <= 1'b1;
    note(6, 16'h0001, 1);
    tick(2);
    pos_current_target_limit <= 16'sh0064;
    current_target_in <= 16'sh07d0;
    note(0, 16'sh03e8, 1);
    // Duty write then global update
    @(posedge clk);
    duty_write <= 1'b1;
    duty_a_in <= 13'h0064;
    duty_b_in <= 13'h0fa0;
    note(3, 16'h0800, 2);
    @(posedge clk);
    duty_write <= 1'b0;
    update_req <= 1'b1;
    note(5, 16'h0001, 1);
    note(5, 16'h0000, 2);
    note(3, {3'h0, `PWM_MIN_DUTY}, 2);
    note(4, {3'h0, `PWM_MAX_DUTY}, 2);
    @(posedge clk);
    update_req <= 1'b0;
    for (int i = 0; i < 10000 && a_high_cycles !== {3'h0, `PWM_MIN_DUTY}; i++) @(posedge clk);
    // One more full period so the measured rise-to-rise is not the one after reset
    tick(4096);
    note(13, {3'h0, `PWM_MIN_DUTY}, 0);
    note(14, 16'h1000, 0);
    note(15, 16'h0001, 0);
    // Counter now past the 80% point, so pin b is low
    tick(2600);
    note(15, 16'h0000, 0);
    tick(2);
    // Current samples back to back: streaks, clean reset, kind switch
    foreach (cur_seq[i]) begin
      @(posedge clk);
      sample_req <= 1'b1;
      sample_current <= 16'(cur_seq[i]);
      sample_voltage <= 16'sh0000;
      note(7, {15'h0000, i == 7}, 3);
    end
    @(posedge clk);
    sample_req <= 1'b0;
    note(5, 16'h0001, 4);
    note(6, 16'h0000, 4);
    note(3, 16'h0800, 5);
    note(4, 16'h0800, 5);
    tick(8);
    control_enable <= 1'b0;
    tick(3);
    note(7, 16'h0000, 0);
    // Samples while stopped are not compared
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      sample_req <= 1'b1;
      sample_current <= 16'sh0384;
      note(7, 16'h0000, 3);
    end
    @(posedge clk);
    sample_req <= 1'b0;
    tick(4);
    control_enable <= 1'b1;
    tick(2);
    // Voltage fault after three over-limit samples
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      sample_req <= 1'b1;
      sample_current <= 16'sh0000;
      sample_voltage <= 16'sh05dd;
      note(8, {15'h0000, i == 2}, 3);
      note(7, 16'h0000, 3);
    end
    @(posedge clk);
    sample_req <= 1'b0;
    for (int i = 0; i < 50 && notes.size() > 0; i++) @(posedge clk);
    if (notes.size() > 0) failures++;
    stop_test();
  end
endmodule // tb_top
